// ---- src/ias_pkg.sv ----
package ias_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register port and register map.
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 16;
  localparam logic [3:0]  REG_LATCH  = 4'h0;
  localparam logic [3:0]  REG_ENABLE = 4'h1;
  localparam logic [3:0]  REG_SELECT = 4'h2;
  localparam logic [3:0]  REG_STATUS = 4'h3;
  localparam logic [3:0]  REG_STACK  = 4'h4;

  // Selector fields: bit 6 picks the shared-level source, bit 5 is reserved.
  localparam int          SEL_SHARED_BIT = 6;
  localparam int          SEL_RSVD_BIT   = 5;
  localparam logic [7:0]  SEL_RESET      = 8'h00;
  localparam logic [7:0]  SEL_WMASK      = 8'h40;

  // Enable register and stacked status byte.
  localparam int          ENA_MASTER_BIT = 0;
  localparam int          PSW_ME_BIT     = 0;
  localparam logic [15:0] SP_RESET       = 16'h023F;

  // Status register fields.
  localparam int          STS_BUSY_BIT   = 0;
  localparam int          STS_NMI_BIT    = 1;
  localparam int          STS_LVL_LO     = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Priority levels; a smaller number wins.
  localparam int          LVL_W       = 4;
  localparam logic [3:0]  LVL_SOFT    = 4'h2;
  localparam logic [3:0]  LVL_MASK_LO = 4'h4;
  localparam logic [3:0]  LVL_SHARED  = 4'hC;

  // Acceptance sequence: machine cycles of four clocks each.
  localparam int          MC_CLKS      = 4;
  localparam int          SEQ_MCYC     = 8;
  localparam int          SEQ_CLKS     = MC_CLKS * SEQ_MCYC;
  localparam logic [4:0]  CNT_PUSH_PSW = 5'(MC_CLKS * 1);
  localparam logic [4:0]  CNT_PUSH_PCH = 5'(MC_CLKS * 2);
  localparam logic [4:0]  CNT_PUSH_PCL = 5'(MC_CLKS * 3);
  localparam logic [4:0]  CNT_VEC_RD   = 5'(MC_CLKS * 4);
  // The vector word arrives the cycle after the registered read strobe.
  localparam logic [4:0]  CNT_VEC_CAP  = 5'(MC_CLKS * 4 + 2);
  localparam logic [4:0]  CNT_LAST     = 5'(SEQ_CLKS - 1);
  localparam int          LAT_MAX_CLKS = 38;

  //////////////////////////////////////////////////////////////////////////////
  // Memory areas and codes.
  localparam logic [7:0]  OPC_SOFT_TRAP = 8'hFF;
  localparam logic [15:0] VEC_TOP       = 16'hFFFE;
  localparam logic [15:0] SFR_LO        = 16'h0000;
  localparam logic [15:0] SFR_HI        = 16'h003F;
  localparam logic [15:0] RAM_LO        = 16'h0040;
  localparam logic [15:0] RAM_HI        = 16'h023F;
  localparam logic [15:0] DBR_LO        = 16'h0F80;
  localparam logic [15:0] DBR_HI        = 16'h0FFF;
  localparam logic [15:0] ROM_LO        = 16'hC000;

endpackage : ias_pkg

// ---- src/ias_req_latch.sv ----
module ias_req_latch (
  input  wire logic        ref_clk_i,             // System clock.
  input  wire logic        rstn_i,                // Sync reset, active low.
  input  wire logic [15:4] src_req_i,             // Per-level requests.
  input  wire logic        timer4_irq_i,          // Shared level source A.
  input  wire logic        ext_pin_irq_three_i,   // Shared level source B.
  input  wire logic        sel_ext_i,             // 1 selects source B.
  input  wire logic [15:4] accept_clr_i,          // Clear on acceptance.
  input  wire logic        sw_wr_i,               // Software latch write.
  input  wire logic [15:4] sw_keep_i,             // Zero bits are cleared.
  output logic      [15:4] request_latch_o        // Latched requests.
);

  typedef struct packed {
    logic [15:4] lat;
  } ias_latch_state_t;

  ias_latch_state_t r_reg;
  ias_latch_state_t r_next;
  logic [15:4]      set_v;

  always_comb begin
    set_v = src_req_i;
    // The unselected shared source is dropped here, never held.
    set_v[ias_pkg::LVL_SHARED] = sel_ext_i ? ext_pin_irq_three_i
                                           : timer4_irq_i;
    r_next = r_reg;
    if (sw_wr_i) begin
      r_next.lat = r_next.lat & sw_keep_i;
    end
    r_next.lat = r_next.lat & ~accept_clr_i;
    // A new request in the clearing cycle survives the clear.
    r_next.lat = r_next.lat | set_v;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign request_latch_o = r_reg.lat;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_latch_holds: assert property (
    r_reg.lat[7] && !accept_clr_i[7] && !sw_wr_i |=> r_reg.lat[7])
    else $error("request latch dropped without a clear");

  a_unselected_drop: assert property (
    !sel_ext_i && ext_pin_irq_three_i && !timer4_irq_i
      && !r_reg.lat[ias_pkg::LVL_SHARED] |=> !r_reg.lat[ias_pkg::LVL_SHARED])
    else $error("unselected shared source was latched");

endmodule : ias_req_latch

// ---- src/ias_prio_pick.sv ----
module ias_prio_pick (
  input  wire logic [15:4] pend_i,     // Enabled pending requests.
  output logic             valid_o,    // Some request pending.
  output logic [3:0]       level_o     // Winning level number.
);

  function automatic logic [3:0] pick_level(input logic [15:4] v);
    logic [3:0] lv;
    lv = 4'h0;
    for (int i = 15; i >= 4; i--) begin
      if (v[i]) begin
        lv = 4'(i);
      end
    end
    return lv;
  endfunction : pick_level

  assign valid_o = |pend_i;
  assign level_o = pick_level(pend_i);

endmodule : ias_prio_pick

// ---- src/ias_accept_seq.sv ----
// Functional notes
// - A shared-level source latches only while the selector picks it.
// - Requests of an unselected shared source are dropped, not held.
// - Timer 4 and external pin three share level 12 via the selector.
// - A set request latch holds until accepted, reset or cleared.
// - Acceptance lasts eight machine cycles after the current instruction.
// - Acceptance first clears the master enable flag.
// - Acceptance clears the accepted source's request latch.
// - Push status with enable, PC high, PC low; stack pointer minus three.
// - After stacking, the vector entry loads the program counter.
// - Latch set to acceptance start takes at most 38 clock periods.
// - No maskable acceptance while the master enable flag is zero.
// - Only program counter and status word are saved automatically.
// - Maskable and non-maskable services end with their own return.
// - Stacked PC low sits at SP plus one, high at SP plus two.
// - Requests are sampled in each instruction's last cycle.
// - The software trap opcode starts highest-priority acceptance at once.
// - Fetch from non-existent memory returns the software trap opcode.
// - Fetch from RAM, data buffer or special registers resets.
// - An undefined opcode raises a trap vectored like the software trap.
// - The undefined-opcode trap aborts even non-maskable service at once.
// - Either return reloads the master enable from the stacked status.
// - Maskable acceptance needs both source enable and master enable.
module ias_accept_seq #(
  parameter logic [15:0] RAM_HI = ias_pkg::RAM_HI,  // Last RAM address.
  parameter logic [15:0] ROM_LO = ias_pkg::ROM_LO   // First program address.
) (
  input  wire logic        ref_clk_i,            // System clock.
  input  wire logic        rstn_i,               // Sync reset, active low.
  input  wire logic [3:0]  reg_addr_i,           // Register address.
  input  wire logic [15:0] reg_wdata_i,          // Register write data.
  input  wire logic        reg_wr_i,             // Write strobe.
  input  wire logic        reg_rd_i,             // Read strobe.
  output logic      [15:0] reg_rdata_o,          // Read data, next cycle.
  input  wire logic [15:4] src_req_i,            // Peripheral requests.
  input  wire logic        timer4_irq_i,         // Timer 4 request.
  input  wire logic        ext_pin_irq_three_i,  // External pin 3 request.
  input  wire logic        instr_last_i,         // Last instruction cycle.
  input  wire logic        soft_trap_irq_i,      // Trap opcode executed.
  input  wire logic        bad_opcode_irq_i,     // Undefined opcode run.
  input  wire logic        ret_maskable_i,       // Maskable return ends.
  input  wire logic        ret_nonmaskable_i,    // Non-maskable return ends.
  input  wire logic [7:0]  ret_psw_i,            // Popped status byte.
  input  wire logic [7:0]  psw_i,                // Current status word.
  input  wire logic [15:0] pc_i,                 // Return address.
  input  wire logic        fetch_i,              // Opcode fetch strobe.
  input  wire logic [15:0] fetch_addr_i,         // Opcode fetch address.
  output logic             fetch_ovr_o,          // Replace fetched code.
  output logic      [7:0]  fetch_data_o,         // Replacement code.
  output logic             trap_reset_o,         // Address trap reset.
  output logic             mem_we_o,             // Stack write strobe.
  output logic             mem_re_o,             // Vector read strobe.
  output logic      [15:0] mem_addr_o,           // Memory address.
  output logic      [7:0]  mem_wdata_o,          // Stack write byte.
  input  wire logic [15:0] vec_data_i,           // Vector word, next cycle.
  output logic             pc_load_o,            // Load program counter.
  output logic      [15:0] pc_value_o,           // Service entry address.
  output logic             busy_o,               // Acceptance in progress.
  output logic             master_irq_enable_o,  // Master enable flag.
  output logic      [15:0] sp_o                  // Stack pointer.
);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SEQ
  } ias_state_t;

  typedef struct packed {
    ias_state_t  st;
    logic [4:0]  cnt;
    logic [3:0]  lvl;
    logic        me;
    logic [15:4] ef;
    logic [7:0]  sel;
    logic [15:0] sp;
    logic        nmi_act;
    logic [7:0]  psw_snap;
    logic [15:0] pc_snap;
    logic [15:4] clr_mask;
    logic        mem_we;
    logic        mem_re;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        pc_load;
    logic [15:0] pc_val;
    logic [15:0] rdata;
    logic        trap_rst;
    logic        fetch_ovr;
  } ias_core_state_t;

  function automatic logic in_area(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_area

  function automatic logic is_maskable(input logic [3:0] lv);
    return lv >= ias_pkg::LVL_MASK_LO;
  endfunction : is_maskable

  ias_core_state_t r_reg;
  ias_core_state_t r_next;
  logic [15:4]     latch_v;
  logic [15:4]     pend_v;
  logic            pick_v;
  logic [3:0]      pick_lvl;
  logic            me_eff;
  logic            ret_any;
  logic            idle;
  logic            start_trap;
  logic            start_mask;
  logic            start;

  //////////////////////////////////////////////////////////////////////////////
  // Request latches and priority selection.
  ias_req_latch u_latch (
    .ref_clk_i           (ref_clk_i),
    .rstn_i              (rstn_i),
    .src_req_i           (src_req_i),
    .timer4_irq_i        (timer4_irq_i),
    .ext_pin_irq_three_i (ext_pin_irq_three_i),
    .sel_ext_i           (r_reg.sel[ias_pkg::SEL_SHARED_BIT]),
    .accept_clr_i        (r_reg.clr_mask),
    .sw_wr_i             (reg_wr_i && reg_addr_i == ias_pkg::REG_LATCH),
    .sw_keep_i           (reg_wdata_i[15:4]),
    .request_latch_o     (latch_v)
  );

  ias_prio_pick u_pick (
    .pend_i  (pend_v),
    .valid_o (pick_v),
    .level_o (pick_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Acceptance decision.
  assign ret_any = ret_maskable_i || ret_nonmaskable_i;
  // A return's last cycle is also a sampling point, so the restored flag
  // must already gate that sample or a queued request would wait a whole
  // instruction longer.
  assign me_eff  = ret_any ? ret_psw_i[ias_pkg::PSW_ME_BIT] : r_reg.me;
  assign pend_v  = latch_v & r_reg.ef & {12{me_eff}};
  assign idle    = r_reg.st == ST_IDLE;
  assign start_trap = bad_opcode_irq_i
                   || (idle && soft_trap_irq_i);
  assign start_mask = idle && instr_last_i && pick_v;
  assign start      = start_trap || start_mask;

  always_comb begin
    r_next           = r_reg;
    r_next.mem_we    = 1'b0;
    r_next.mem_re    = 1'b0;
    r_next.pc_load   = 1'b0;
    r_next.rdata     = '0;
    r_next.clr_mask  = '0;
    r_next.trap_rst  = 1'b0;
    r_next.fetch_ovr = 1'b0;

    // Register port.
    if (reg_wr_i) begin
      case (reg_addr_i)
        ias_pkg::REG_ENABLE: begin
          r_next.me = reg_wdata_i[ias_pkg::ENA_MASTER_BIT];
          r_next.ef = reg_wdata_i[15:4];
        end
        ias_pkg::REG_SELECT: begin
          // Only the source pick is stored; bit 5 always reads zero.
          r_next.sel = reg_wdata_i[7:0] & ias_pkg::SEL_WMASK;
        end
        ias_pkg::REG_STACK: r_next.sp = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ias_pkg::REG_LATCH:  r_next.rdata = {latch_v, 4'h0};
        ias_pkg::REG_ENABLE: r_next.rdata = {r_reg.ef, 3'h0, r_reg.me};
        ias_pkg::REG_SELECT: r_next.rdata = {8'h00, r_reg.sel};
        ias_pkg::REG_STATUS: begin
          r_next.rdata = {8'h00, r_reg.lvl, 2'h0, r_reg.nmi_act,
                          r_reg.st == ST_SEQ};
        end
        ias_pkg::REG_STACK:  r_next.rdata = r_reg.sp;
        default: r_next.rdata = '0;
      endcase
    end

    // Opcode fetch checks.
    if (fetch_i) begin
      if (in_area(fetch_addr_i, ias_pkg::SFR_LO, ias_pkg::SFR_HI)
          || in_area(fetch_addr_i, ias_pkg::RAM_LO, RAM_HI)
          || in_area(fetch_addr_i, ias_pkg::DBR_LO, ias_pkg::DBR_HI)) begin
        r_next.trap_rst = 1'b1;
      end else if (fetch_addr_i < ROM_LO) begin
        r_next.fetch_ovr = 1'b1;
      end
    end

    // Returns restore the flag and release the three stacked bytes.
    if (ret_any) begin
      r_next.me = ret_psw_i[ias_pkg::PSW_ME_BIT];
      r_next.sp = r_next.sp + 16'h0003;
      if (ret_nonmaskable_i) begin
        r_next.nmi_act = 1'b0;
      end
    end

    // Acceptance sequence.
    case (r_reg.st)
      ST_IDLE: begin
        if (start) begin
          r_next.st       = ST_SEQ;
          r_next.cnt      = '0;
          r_next.lvl      = start_trap ? ias_pkg::LVL_SOFT : pick_lvl;
          r_next.psw_snap = {psw_i[7:1], me_eff};
          r_next.pc_snap  = pc_i;
          r_next.me       = 1'b0;
          if (start_trap) begin
            r_next.nmi_act = 1'b1;
          end else begin
            r_next.clr_mask[pick_lvl] = 1'b1;
          end
        end
      end
      ST_SEQ: begin
        r_next.cnt = r_reg.cnt + 5'h01;
        case (r_reg.cnt)
          ias_pkg::CNT_PUSH_PSW: begin
            r_next.mem_we    = 1'b1;
            r_next.mem_addr  = r_reg.sp;
            r_next.mem_wdata = r_reg.psw_snap;
          end
          ias_pkg::CNT_PUSH_PCH: begin
            r_next.mem_we    = 1'b1;
            r_next.mem_addr  = r_reg.sp - 16'h0001;
            r_next.mem_wdata = r_reg.pc_snap[15:8];
          end
          ias_pkg::CNT_PUSH_PCL: begin
            r_next.mem_we    = 1'b1;
            r_next.mem_addr  = r_reg.sp - 16'h0002;
            r_next.mem_wdata = r_reg.pc_snap[7:0];
            r_next.sp        = r_next.sp - 16'h0003;
          end
          ias_pkg::CNT_VEC_RD: begin
            r_next.mem_re   = 1'b1;
            r_next.mem_addr = ias_pkg::VEC_TOP - 16'({r_reg.lvl, 1'b0});
          end
          ias_pkg::CNT_VEC_CAP: r_next.pc_val = vec_data_i;
          ias_pkg::CNT_LAST: begin
            r_next.pc_load = 1'b1;
            r_next.st      = ST_IDLE;
          end
          default: ;
        endcase
        // An undefined opcode breaks off whatever is under way.
        if (bad_opcode_irq_i) begin
          r_next.st       = ST_SEQ;
          r_next.cnt      = '0;
          r_next.lvl      = ias_pkg::LVL_SOFT;
          r_next.psw_snap = {psw_i[7:1], r_reg.me};
          r_next.pc_snap  = pc_i;
          r_next.nmi_act  = 1'b1;
          r_next.me       = 1'b0;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r_reg     <= '0;
      r_reg.st  <= ST_IDLE;
      r_reg.sel <= ias_pkg::SEL_RESET;
      r_reg.sp  <= ias_pkg::SP_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign reg_rdata_o         = r_reg.rdata;
  assign fetch_ovr_o         = r_reg.fetch_ovr;
  assign fetch_data_o        = r_reg.fetch_ovr ? ias_pkg::OPC_SOFT_TRAP
                                               : 8'h00;
  assign trap_reset_o        = r_reg.trap_rst;
  assign mem_we_o            = r_reg.mem_we;
  assign mem_re_o            = r_reg.mem_re;
  assign mem_addr_o          = r_reg.mem_addr;
  assign mem_wdata_o         = r_reg.mem_wdata;
  assign pc_load_o           = r_reg.pc_load;
  assign pc_value_o          = r_reg.pc_val;
  assign busy_o              = r_reg.st == ST_SEQ;
  assign master_irq_enable_o = r_reg.me;
  assign sp_o                = r_reg.sp;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_start_clears_me: assert property (
    start && !reg_wr_i |=> busy_o && !master_irq_enable_o)
    else $error("master enable not cleared at acceptance");

  a_latch_clear: assert property (
    start_mask && !start_trap |=> r_reg.clr_mask[$past(pick_lvl)])
    else $error("accepted latch not cleared");

  a_gate_enable: assert property (
    start_mask |-> is_maskable(pick_lvl) && me_eff && r_reg.ef[pick_lvl]
                   && latch_v[pick_lvl])
    else $error("maskable request accepted while disabled");

  a_sample_point: assert property (
    $rose(busy_o) && !$past(start_trap) |-> $past(instr_last_i))
    else $error("maskable acceptance outside the sampling point");

  a_fast_start: assert property (
    idle && instr_last_i && pick_v |=> busy_o)
    else $error("enabled request not started at sampling point");

  a_soft_now: assert property (
    idle && soft_trap_irq_i |=> busy_o && r_reg.lvl == ias_pkg::LVL_SOFT)
    else $error("software trap did not start at once");

  a_push_order: assert property (
    busy_o && r_reg.cnt == ias_pkg::CNT_PUSH_PSW && !bad_opcode_irq_i
    |=> mem_we_o && mem_addr_o == $past(sp_o)
        ##4 mem_we_o && mem_addr_o == $past(sp_o, 4) - 16'h0001)
    else $error("status or PC high pushed at the wrong place");

  a_stack_frame: assert property (
    busy_o && r_reg.cnt == ias_pkg::CNT_PUSH_PCL && !bad_opcode_irq_i
      && !ret_any && !reg_wr_i
    |=> mem_addr_o == sp_o + 16'h0001 && sp_o == $past(sp_o) - 16'h0003)
    else $error("stack frame misplaced");

  a_seq_length: assert property (
    idle && start
    ##1 !bad_opcode_irq_i [*8] ##1 !bad_opcode_irq_i [*8]
    ##1 !bad_opcode_irq_i [*8] ##1 !bad_opcode_irq_i [*7]
    ##1 (!bad_opcode_irq_i && busy_o && !pc_load_o)
    |=> pc_load_o && !busy_o)
    else $error("acceptance length is not eight machine cycles");

  a_ret_restore: assert property (
    ret_any && !start && !reg_wr_i
    |=> master_irq_enable_o == $past(ret_psw_i[ias_pkg::PSW_ME_BIT]))
    else $error("return did not restore master enable");

  a_trap_reset: assert property (
    fetch_i && fetch_addr_i <= ias_pkg::SFR_HI |=> trap_reset_o)
    else $error("fetch from register area did not reset");

  c_maskable: cover property (start_mask ##33 pc_load_o);
  c_soft_trap: cover property (idle && soft_trap_irq_i ##33 pc_load_o);
  c_undef_abort: cover property (busy_o && bad_opcode_irq_i);
  c_return_then_accept: cover property (ret_maskable_i && start_mask);

endmodule : ias_accept_seq

// ---- verif/ias_cpu_model.sv ----
module ias_cpu_model (
  input  wire logic        ref_clk_i,    // System clock.
  input  wire logic        mem_we_i,     // Stack write strobe.
  input  wire logic        mem_re_i,     // Vector read strobe.
  input  wire logic [15:0] mem_addr_i,   // Memory address.
  input  wire logic [7:0]  mem_wdata_i,  // Stack write byte.
  output logic      [15:0] vec_data_o    // Vector word.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  stk [0:1023];
  logic        re_q;
  logic [15:0] vec;
  // Each vector slot holds its own entry, so a wrong level shows up.
  assign vec = 16'hC000 | {4'h0, mem_addr_i[11:0]};
  // The word stands only the cycle after the strobe; it is inverted
  // otherwise, so an early or late sample fails.
  assign vec_data_o = re_q ? vec : ~vec;
  always_ff @(posedge ref_clk_i) begin
    re_q <= mem_re_i;
    if (mem_we_i) begin
      stk[mem_addr_i[9:0]] <= mem_wdata_i;
    end
  end
endmodule : ias_cpu_model

// ---- verif/ias_accept_seq_bench.sv ----
module ias_accept_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  pul = 8'h00, rpsw = 8'h00, program_status_word = 8'h80, fdat, mwd;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wd = 16'h0000, fa = 16'h0000, rdata, maddr, vec, pcv, sp;
  logic [15:4] src = 12'h000;
  logic        fovr, trst, we, re, pc_low_byte, busy, me;
  int          failures = 0, samples_checked = 0, nwe = 0, n;
  ias_accept_seq ias_accept_seq_i (
    .ref_clk_i(clk), .rstn_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .src_req_i(src),
    .timer4_irq_i(pul[7]), .ext_pin_irq_three_i(pul[6]),
    .instr_last_i(pul[5]), .soft_trap_irq_i(pul[4]),
    .bad_opcode_irq_i(pul[3]), .ret_maskable_i(pul[2]),
    .ret_nonmaskable_i(pul[1]), .ret_psw_i(rpsw), .psw_i(program_status_word),
    .pc_i(16'h1234), .fetch_i(pul[0]), .fetch_addr_i(fa),
    .fetch_ovr_o(fovr), .fetch_data_o(fdat), .trap_reset_o(trst),
    .mem_we_o(we), .mem_re_o(re), .mem_addr_o(maddr), .mem_wdata_o(mwd),
    .vec_data_i(vec), .pc_load_o(pc_low_byte), .pc_value_o(pcv), .busy_o(busy),
    .master_irq_enable_o(me), .sp_o(sp));
  ias_cpu_model ias_cpu_model_i (
    .ref_clk_i(clk), .mem_we_i(we), .mem_re_i(re), .mem_addr_i(maddr),
    .mem_wdata_i(mwd), .vec_data_o(vec));
  //////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  always @(posedge clk) if (we === 1'b1) nwe++;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  // Pulses one cycle; returns just after the edge that takes the pulse.
  task automatic kick(input logic [7:0] m, input logic [15:4] s = 12'h000);
    @(posedge clk);
    pul <= m;
    src <= s;
    @(posedge clk);
    pul <= 8'h00;
    src <= 12'h000;
  endtask : kick
  task automatic acc(input logic [15:0] epc, input logic [15:0] esp);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (pc_low_byte !== 1'b1 && n < 60);
    chk(16'(n), 16'h0020);
    chk(pcv, epc);
    chk(sp, esp);
  endtask : acc
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(4'h2, 16'h0000);
    rd_chk(4'h4, 16'h023F);
    rd_chk(4'h1, 16'h0000);
    rd_chk(4'h7, 16'h0000);
    kick(8'h40);
    rd_chk(4'h0, 16'h0000);
    kick(8'h80);
    rd_chk(4'h0, 16'h1000);
    wr_reg(4'h0, 16'h0000);
    rd_chk(4'h0, 16'h0000);
    wr_reg(4'h2, 16'h0040);
    rd_chk(4'h2, 16'h0040);
    kick(8'h80);
    rd_chk(4'h0, 16'h0000);
    kick(8'h40, 12'h001);
    rd_chk(4'h0, 16'h1010);
    wr_reg(4'h1, 16'h1010);
    kick(8'h20);
    repeat (4) @(posedge clk);
    #1 chk(16'(busy), 16'h0000);
    wr_reg(4'h1, 16'h1011);
    kick(8'h20);
    acc(16'hCFF6, 16'h023C);
    chk(16'(me), 16'h0000);
    chk(16'(ias_cpu_model_i.stk[10'h23F]), 16'h0081);
    chk(16'(ias_cpu_model_i.stk[10'h23E]), 16'h0012);
    chk(16'(ias_cpu_model_i.stk[10'h23D]), 16'h0034);
    chk(16'(nwe), 16'h0003);
    rd_chk(4'h0, 16'h1000);
    rpsw <= 8'h01;
    kick(8'h24);
    acc(16'hCFE6, 16'h023C);
    kick(8'h04);
    #1 chk({15'h0000, me}, 16'h0001);
    chk(sp, 16'h023F);
    wr_reg(4'h1, 16'h0000);
    kick(8'h10);
    acc(16'hCFFA, 16'h023C);
    // The undefined opcode lands after the first frame is pushed.
    kick(8'h10);
    repeat (19) @(posedge clk);
    kick(8'h08);
    acc(16'hCFFA, 16'h0236);
    rd_chk(4'h3, 16'h0022);
    chk({ias_cpu_model_i.stk[10'h238],
         ias_cpu_model_i.stk[10'h237]}, 16'h1234);
    rpsw <= 8'h00;
    kick(8'h02);
    #1 chk(sp, 16'h0239);
    rd_chk(4'h3, 16'h0020);
    fa <= 16'h8000;
    kick(8'h01);
    #1 chk({fovr, 7'h00, fdat}, 16'h80FF);
    fa <= 16'h0100;
    kick(8'h01);
    #1 chk(16'(trst), 16'h0001);
    test_done;
  end
  initial begin
    #50_000;
    failures++;
    test_done;
  end
endmodule : ias_accept_seq_bench
